// file: logic/half_addr_expander.sv
// Second-half operand addresses for a compressed instruction split in two
`include "region_cfg.svh"

module half_addr_expander #(
	parameter int IDX_ENTRIES = 16
) (
	input wire region_pkg::insn_t insn,
	input wire region_pkg::geom_t geom,
	input wire logic [IDX_ENTRIES*16-1:0] idx_flat,
	output region_pkg::half_addr_t half
);
	import region_pkg::*;

	logic [15:0] idx [IDX_ENTRIES];
	logic [5:0] half_elems;
	logic [5:0] row_step;

	genvar g;
	generate
		for (g = 0; g < IDX_ENTRIES; g++)
		begin : g_idx
			assign idx[g] = idx_flat[g*16 +: 16];
		end
	endgenerate

	// Half of the execution size, in elements
	assign half_elems = 6'(6'h01 << insn.exec_log) >> 1;
	// Entry advances once per row of width elements
	assign row_step = half_elems >> geom.width_log;

	always_comb
	begin
		// One index register covers both halves, one register apart
		half.dst_hi = idx[0] + `REG_BYTES;
		half.first_source_operand_hi = idx[0];
		if (insn.first_source_operand_mode == `AM_PER_ROW || insn.first_source_operand_mode == `AM_PER_ELEM)
		begin
			// Walking past the table wraps rather than faulting
			half.first_source_operand_hi = idx[row_step[3:0]];
		end
		else if (insn.first_source_operand_mode == `AM_SINGLE && !geom.first_source_operand_scalar)
		begin
			half.first_source_operand_hi = idx[0] + `REG_BYTES;
		end
		else if (insn.first_source_operand_mode == `AM_SINGLE)
		begin
			// Scalar source keeps one address for every channel
			half.first_source_operand_hi = idx[0];
		end
	end

endmodule : half_addr_expander

// file: logic/operand_region_legality_unit.sv
// Operand region legality checker with indirect half-address expansion
`include "region_cfg.svh"

module operand_region_legality_unit #(
	parameter int IDX_ENTRIES = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic check_busy,
	output logic check_fault
);
	import region_pkg::*;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [31:0] ctrl_r;
	insn_t insn_r;
	geom_t geom_r;
	logic [IDX_ENTRIES*16-1:0] idx_r;
	logic [31:0] viol_r;
	logic [31:0] viol_nxt;
	logic [3:0] flags_r;
	half_addr_t half_r;
	half_addr_t half_nxt;
	logic [15:0] pass_cnt_r;
	logic [15:0] fail_cnt_r;
	chk_state_t state_r;
	logic [31:0] prdata_r;
	logic slverr_r;

	logic setup;
	logic wr_en;
	logic start;
	logic idx_hit;
	logic [3:0] idx_sel;
	logic preempt;
	logic vx_first_source_operand;
	logic packed_dst;
	logic [6:0] hf_end;

	assign setup = psel && !penable;
	assign pready = psel && penable;
	assign wr_en = pready && pwrite;
	assign idx_hit = paddr >= `RG_IDX_BASE && paddr <= `RG_IDX_LAST;
	assign idx_sel = paddr[5:2];
	assign start = wr_en && paddr == `RG_CMD_OFF && pwdata[`CMD_START_BIT];
	assign preempt = ctrl_r[`CTRL_PREEMPT_BIT];
	assign prdata = prdata_r;
	assign pslverr = slverr_r;
	assign check_busy = state_r != ST_IDLE;
	assign check_fault = viol_r != 32'h0000_0000;

	// ------------------------------------------------------------------
	// Software writes
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= `CTRL_RESET;
			insn_r <= `INSN_RESET;
			geom_r <= `GEOM_RESET;
		end
		else if (wr_en && paddr == `RG_CTRL_OFF)
		begin
			ctrl_r <= pwdata;
		end
		else if (wr_en && paddr == `RG_INSN_OFF && state_r == ST_IDLE)
		begin
			// Descriptor is frozen while a check is running
			insn_r <= pwdata;
		end
		else if (wr_en && paddr == `RG_GEOM_OFF && state_r == ST_IDLE)
		begin
			geom_r <= pwdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < IDX_ENTRIES; g++)
		begin : g_idx_reg
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					idx_r[g*16 +: 16] <= `IDX_RESET;
				end
				else if (wr_en && idx_hit && idx_sel == 4'(g) && paddr[1:0] == 2'h0)
				begin
					idx_r[g*16 +: 16] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Legality evaluation
	// ------------------------------------------------------------------
	assign vx_first_source_operand = insn_r.first_source_operand_mode == `AM_PER_ROW ||
		insn_r.first_source_operand_mode == `AM_PER_ELEM;
	// Packed half destination in either access mode
	assign packed_dst = insn_r.dst_hf &&
		(insn_r.four_comp || insn_r.dst_hs == `HS_ONE);
	assign hf_end = 7'(geom_r.hf_start) + 7'(geom_r.hf_len);

	always_comb
	begin
		viol_nxt = 32'h0000_0000;
		viol_nxt[2] = insn_r.mixed && insn_r.four_comp &&
			((geom_r.hf_start & `OWORD_MASK) != 5'h00 ||
			hf_end > 7'(geom_r.hf_start) + `OWORD_BYTES);
		viol_nxt[3] = insn_r.mixed && packed_dst &&
			insn_r.exec_log == `EXEC_LOG_16;
		viol_nxt[4] = insn_r.four_comp && insn_r.mixed &&
			insn_r.src_acc;
		viol_nxt[5] = insn_r.src_acc && insn_r.dst_hf &&
			insn_r.dst_hs == `HS_ONE && insn_r.acc_off_nz;
		viol_nxt[6] = ((insn_r.src_acc || insn_r.implicit_acc) &&
			insn_r.swizzle) || (insn_r.implicit_acc && insn_r.dst_hf &&
			insn_r.dst_hs != `HS_TWO);
		viol_nxt[7] = insn_r.four_comp && (insn_r.dst_hf || insn_r.mixed)
			&& insn_r.hf_vstride_zero;
		viol_nxt[8] = insn_r.is_math && insn_r.mixed &&
			(insn_r.four_comp ? !insn_r.src_packed :
			!insn_r.hf_src_strided);
		// Scalar mode packed half output keeps oword placement
		viol_nxt[9] = !insn_r.four_comp && packed_dst && insn_r.mixed &&
			((geom_r.dst_off & `OWORD_MASK) != 5'h00);
		viol_nxt[11] = insn_r.compressed && insn_r.first_source_operand_mode ==
			`AM_SINGLE && insn_r.src_two_reg;
		viol_nxt[12] = insn_r.second_source_operand_mode == `AM_PER_ROW ||
			insn_r.second_source_operand_mode == `AM_PER_ELEM;
		viol_nxt[14] = insn_r.dst_indirect &&
			insn_r.dst_multi_mode;
		viol_nxt[15] = insn_r.exec_log == `EXEC_LOG_32 && vx_first_source_operand;
		viol_nxt[16] = insn_r.is_flow && insn_r.four_comp;
		viol_nxt[17] = insn_r.four_comp && insn_r.size_conv &&
			insn_r.conv_multi_reg;
		viol_nxt[18] = insn_r.four_comp && insn_r.src_two_reg;
		viol_nxt[19] = insn_r.int_hf_conv &&
			((geom_r.dst_off & `DWORD_MASK) != 5'h00 ||
			insn_r.dst_hs != `HS_TWO);
		viol_nxt[20] = insn_r.compressed && insn_r.half_overlap;
		viol_nxt[21] = preempt && insn_r.compressed && vx_first_source_operand &&
			!insn_r.first_source_operand_multi_idx;
	end

	half_addr_expander #(
		.IDX_ENTRIES(IDX_ENTRIES)
	) u_expander (
		.insn(insn_r),
		.geom(geom_r),
		.idx_flat(idx_r),
		.half(half_nxt)
	);

	// ------------------------------------------------------------------
	// Check sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_IDLE;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					if (start && ctrl_r[`CTRL_ENABLE_BIT])
					begin
						state_r <= ST_CHECK;
					end
				ST_CHECK:
					state_r <= ST_EXPAND;
				ST_EXPAND:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			viol_r <= 32'h0000_0000;
			flags_r <= 4'h0;
			pass_cnt_r <= 16'h0000;
			fail_cnt_r <= 16'h0000;
		end
		else if (state_r == ST_CHECK)
		begin
			viol_r <= viol_nxt;
			// Counters saturate so software can poll slowly
			if (viol_nxt != 32'h0000_0000 && fail_cnt_r != 16'hFFFF)
			begin
				fail_cnt_r <= fail_cnt_r + 16'h0001;
			end
			else if (viol_nxt == 32'h0000_0000 && pass_cnt_r != 16'hFFFF)
			begin
				pass_cnt_r <= pass_cnt_r + 16'h0001;
			end
			flags_r[0] <= insn_r.four_comp && insn_r.mixed;
			flags_r[1] <= packed_dst;
			// Replicated mixed sources may pair in one issue slot
			flags_r[2] <= insn_r.four_comp && insn_r.mixed;
			flags_r[3] <= !insn_r.four_comp && packed_dst;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			half_r <= '0;
		end
		else if (state_r == ST_EXPAND)
		begin
			half_r <= half_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Read path, captured in the setup cycle
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end
		else if (setup)
		begin
			slverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			if (paddr == `RG_CTRL_OFF)
			begin
				prdata_r <= ctrl_r;
			end
			else if (paddr == `RG_INSN_OFF)
			begin
				prdata_r <= insn_r;
			end
			else if (paddr == `RG_GEOM_OFF)
			begin
				prdata_r <= geom_r;
			end
			else if (paddr == `RG_CMD_OFF)
			begin
				prdata_r <= {31'h0000_0000, check_busy};
			end
			else if (paddr == `RG_VIOL_OFF)
			begin
				prdata_r <= viol_r;
			end
			else if (paddr == `RG_STAT_OFF)
			begin
				prdata_r <= {26'h0, flags_r, check_fault, check_busy};
			end
			else if (paddr == `RG_DST_HI_OFF)
			begin
				prdata_r <= {16'h0000, half_r.dst_hi};
			end
			else if (paddr == `RG_SRC_HI_OFF)
			begin
				prdata_r <= {16'h0000, half_r.first_source_operand_hi};
			end
			else if (paddr == `RG_COUNT_OFF)
			begin
				prdata_r <= {fail_cnt_r, pass_cnt_r};
			end
			else if (idx_hit && paddr[1:0] == 2'h0)
			begin
				prdata_r <= {16'h0000, idx_r[idx_sel*16 +: 16]};
			end
			else
			begin
				// Unmapped or misaligned word: error, read zero
				slverr_r <= 1'b1;
			end
			if (paddr[1:0] != 2'h0)
			begin
				slverr_r <= 1'b1;
			end
		end
	end

endmodule : operand_region_legality_unit

// file: logic/region_cfg.svh
// Register offsets, field positions, reset values and encodings of the region unit
`ifndef REGION_CFG_SVH
`define REGION_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RG_CTRL_OFF 12'h000
`define RG_INSN_OFF 12'h004
`define RG_GEOM_OFF 12'h008
`define RG_CMD_OFF 12'h00C
`define RG_VIOL_OFF 12'h010
`define RG_STAT_OFF 12'h014
`define RG_DST_HI_OFF 12'h018
`define RG_SRC_HI_OFF 12'h01C
`define RG_COUNT_OFF 12'h020
`define RG_IDX_BASE 12'h040
`define RG_IDX_LAST 12'h07C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_PREEMPT_BIT 1
`define CMD_START_BIT 0
`define CTRL_RESET 32'h0000_0001
`define INSN_RESET 32'h0000_0000
`define GEOM_RESET 32'h0000_0000
`define IDX_RESET 16'h0000

// ----------------------------------------------------------------------
// Encodings and sizes
// ----------------------------------------------------------------------
`define AM_DIRECT 2'h0
`define AM_SINGLE 2'h1
`define AM_PER_ROW 2'h2
`define AM_PER_ELEM 2'h3
`define HS_ONE 2'h1
`define HS_TWO 2'h2
`define EXEC_LOG_16 3'h4
`define EXEC_LOG_32 3'h5
`define REG_BYTES 16'h0020
`define OWORD_MASK 5'h0F
`define OWORD_BYTES 7'h10
`define DWORD_MASK 5'h03

`endif

// file: logic/region_pkg.sv
// Types shared by the region legality unit and its address expander
package region_pkg;

	// Operand descriptor written by software, one 32-bit word
	typedef struct packed {
		logic [1:0] rsv;
		logic dst_multi_mode;
		logic acc_off_nz;
		logic first_source_operand_multi_idx;
		logic half_overlap;
		logic conv_multi_reg;
		logic src_two_reg;
		logic hf_src_strided;
		logic src_packed;
		logic hf_vstride_zero;
		logic swizzle;
		logic implicit_acc;
		logic src_acc;
		logic [1:0] second_source_operand_mode;
		logic [1:0] first_source_operand_mode;
		logic dst_indirect;
		logic [1:0] dst_hs;
		logic [2:0] exec_log;
		logic compressed;
		logic int_hf_conv;
		logic size_conv;
		logic is_flow;
		logic is_math;
		logic dst_hf;
		logic mixed;
		logic four_comp;
	} insn_t;

	// Region geometry word
	typedef struct packed {
		logic [7:0] rsv;
		logic [2:0] width_log;
		logic first_source_operand_scalar;
		logic [4:0] dst_off;
		logic [4:0] hf_start;
		logic [5:0] hf_len;
		logic [3:0] rsv2;
	} geom_t;

	// Addresses of the second half of a split instruction
	typedef struct packed {
		logic [15:0] dst_hi;
		logic [15:0] first_source_operand_hi;
	} half_addr_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_EXPAND
	} chk_state_t;

endpackage : region_pkg

// file: tb/insn_stream_model.sv
// Instruction stream source: hands descriptors over the APB port
module insn_stream_model (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] rd;
	logic err;
	logic held = 1'b0;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// A kept request lets the next setup follow with no idle cycle
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic keep);
		if (!held)
			@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		held = keep;
		if (!keep)
		begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : xfer
endmodule : insn_stream_model

// file: tb/region_asserts.sv
// Bus and check-timing assertions for the region legality unit
`include "region_cfg.svh"
module region_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic check_busy,
	input wire logic check_fault
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic en_r;
	assign acc = psel && penable;
	// Starts are dropped while disabled, so the enable bit is tracked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_r <= 1'b1;
		else if (acc && pwrite && paddr == `RG_CTRL_OFF)
			en_r <= pwdata[`CTRL_ENABLE_BIT];
	end
	sequence start_s;
		acc && pwrite && paddr == `RG_CMD_OFF && pwdata[0] && en_r
			&& !check_busy;
	endsequence
	sequence run_s;
		check_busy [*2] ##1 !check_busy;
	endsequence
	ready_zero_wait_a: assert property (pready == acc)
		else $error("pready not psel and penable");
	busy_span_a: assert property (start_s |=> run_s)
		else $error("busy span wrong");
	busy_cause_a: assert property ($rose(check_busy)
		|-> $past(acc && pwrite && paddr == `RG_CMD_OFF))
		else $error("busy rose without start");
	err_unaligned_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access accepted");
	err_mapped_a: assert property (acc && paddr == `RG_VIOL_OFF |-> !pslverr)
		else $error("mapped access refused");
	err_zero_a: assert property (acc && !pwrite && pslverr
		|-> prdata == 32'h0) else $error("refused read gave data");
	fault_match_a: assert property (acc && !pwrite
		&& paddr == `RG_VIOL_OFF && !check_busy && $past(!check_busy)
		|-> check_fault == (prdata != 32'h0)) else $error("fault flag wrong");
	busy_read_a: assert property (acc && !pwrite && paddr == `RG_CMD_OFF
		|-> prdata[0] == $past(check_busy)) else $error("busy bit wrong");
endmodule : region_asserts

bind operand_region_legality_unit region_asserts u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .check_busy(check_busy), .check_fault(check_fault));

// file: tb/tb_operand_region_legality_unit.sv
// Self-checking bench for the operand region legality unit
`include "region_cfg.svh"
module tb_operand_region_legality_unit;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic pre; logic [31:0] insn, geom; int bno;} vec_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic check_busy, check_fault;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int err_total = 0, checks = 0, pass_n = 0, fail_n = 0;
	// Violated bit per descriptor; zero marks a legal one
	vec_t vecs [] = '{
		'{0, 32'h11, 32'h0, 16}, '{0, 32'h10, 32'h0, 0},
		'{0, 32'hC06, 32'h0, 3}, '{0, 32'h0, 32'h0, 0},
		'{0, 32'h3, 32'h2100, 2}, '{0, 32'h3, 32'h4100, 0},
		'{0, 32'h40003, 32'h0, 4}, '{0, 32'h10040804, 32'h0, 5},
		'{0, 32'h140000, 32'h0, 6}, '{0, 32'h80804, 32'h0, 6},
		'{0, 32'h200003, 32'h0, 7}, '{0, 32'hB, 32'h0, 8},
		'{0, 32'hA, 32'h0, 8}, '{0, 32'h80000A, 32'h0, 0},
		'{0, 32'h806, 32'h20000, 9}, '{0, 32'h1004080, 32'h0, 11},
		'{0, 32'h20000, 32'h0, 12}, '{0, 32'h30000, 32'h0, 12},
		'{0, 32'h20002000, 32'h0, 14}, '{0, 32'h8500, 32'h0, 15},
		'{0, 32'hC500, 32'h0, 15}, '{0, 32'h2000021, 32'h0, 17},
		'{0, 32'h1000001, 32'h0, 18}, '{0, 32'h840, 32'h0, 19},
		'{0, 32'h1040, 32'h0, 0}, '{0, 32'h4000080, 32'h0, 20},
		'{1, 32'h8080, 32'h0, 21}, '{1, 32'h8008080, 32'h0, 0},
		'{0, 32'h8080, 32'h0, 0}};
	operand_region_legality_unit #(.IDX_ENTRIES(16)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .check_busy(check_busy),
		.check_fault(check_fault));
	insn_stream_model u_host (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	initial
	begin
		pclk = 1'b0;
		forever
			#5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, 1'b0);
		chk(u_host.rd, exp);
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, 1'b0);
	endtask : wr
	task automatic poll;
		do
			u_host.xfer(1'b0, `RG_CMD_OFF, 32'h0, 1'b0);
		while (u_host.rd[0] !== 1'b0);
	endtask : poll
	task automatic run(input logic pre, input logic [31:0] i,
		input logic [31:0] g, input int b);
		wr(`RG_CTRL_OFF, {30'h0, pre, 1'b1});
		wr(`RG_INSN_OFF, i);
		wr(`RG_GEOM_OFF, g);
		wr(`RG_CMD_OFF, 32'h1);
		poll();
		rd(`RG_VIOL_OFF, (b == 0) ? 32'h0 : 32'h1 << b);
		u_host.xfer(1'b0, `RG_STAT_OFF, 32'h0, 1'b0);
		chk(u_host.rd & 32'h2, (b == 0) ? 32'h0 : 32'h2);
		if (b == 0)
			pass_n++;
		else
			fail_n++;
	endtask : run
	task automatic give_verdict;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		give_verdict();
	end
	initial
	begin
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`RG_CTRL_OFF, `CTRL_RESET);
		rd(`RG_INSN_OFF, `INSN_RESET);
		rd(`RG_GEOM_OFF, `GEOM_RESET);
		rd(`RG_COUNT_OFF, 32'h0);
		rd(12'h030, 32'h0);
		chk({31'h0, u_host.err}, 32'h1);
		wr(12'h006, 32'h1);
		chk({31'h0, u_host.err}, 32'h1);
		foreach (vecs[k])
			run(vecs[k].pre, vecs[k].insn, vecs[k].geom, vecs[k].bno);
		wr(`RG_IDX_BASE, 32'h100);
		wr(`RG_IDX_BASE + 12'h008, 32'h2A0);
		run(1'b0, 32'h8480, 32'h400000, 0);
		rd(`RG_DST_HI_OFF, 32'h120);
		rd(`RG_SRC_HI_OFF, 32'h2A0);
		run(1'b0, 32'h4480, 32'h100000, 0);
		rd(`RG_SRC_HI_OFF, 32'h100);
		run(1'b0, 32'h4480, 32'h0, 0);
		rd(`RG_SRC_HI_OFF, 32'h120);
		wr(`RG_IDX_BASE + 12'h020, 32'h3C0);
		wr(`RG_IDX_BASE + 12'h021, 32'h5);
		chk({31'h0, u_host.err}, 32'h1);
		run(1'b0, 32'hC480, 32'h0, 0);
		rd(`RG_SRC_HI_OFF, 32'h3C0);
		run(1'b0, 32'h806, 32'h0, 0);
		u_host.xfer(1'b0, `RG_STAT_OFF, 32'h0, 1'b0);
		chk(u_host.rd & 32'h28, 32'h28);
		run(1'b0, 32'h3, 32'h0, 0);
		u_host.xfer(1'b0, `RG_STAT_OFF, 32'h0, 1'b0);
		chk(u_host.rd & 32'h4, 32'h4);
		chk(u_host.rd & 32'h10, 32'h10);
		wr(`RG_INSN_OFF, 32'h0);
		u_host.xfer(1'b1, `RG_CMD_OFF, 32'h1, 1'b1);
		wr(`RG_INSN_OFF, 32'h11);
		poll();
		pass_n++;
		rd(`RG_INSN_OFF, 32'h0);
		wr(`RG_CTRL_OFF, 32'h0);
		wr(`RG_CMD_OFF, 32'h1);
		rd(`RG_CMD_OFF, 32'h0);
		rd(`RG_COUNT_OFF, {fail_n[15:0], pass_n[15:0]});
		give_verdict();
	end
endmodule : tb_operand_region_legality_unit
